// ### pkg/itli_cfg.svh
// Offsets, field positions, reset values and frame layout of the
// line interface. Assumes a 32-bit word register port, byte addressed.
`ifndef ITLI_CFG_SVH
`define ITLI_CFG_SVH

// ============================================================
// Register map
`define ITLI_OFS_MODE 8'h00
`define ITLI_OFS_MASK 8'h04
`define ITLI_OFS_STATUS 8'h08
`define ITLI_OFS_IRQ_EN 8'h0C
`define ITLI_MODE_RST 16'h0000
`define ITLI_MASK_RST 16'hFFFF

// ============================================================
// Mode register fields
`define ITLI_FORCE_LOW_BIT 15
`define ITLI_SYNC_TERM_BIT 14
`define ITLI_B2_ROUTE_LO 8
`define ITLI_B1_ROUTE_LO 6
`define ITLI_D_ROUTE_LO 4
`define ITLI_MODE_LO 0
`define ITLI_MODE_TEN_CODE 2'h1
`define ITLI_MODE_FOUR_CODE 2'h2

// ============================================================
// Status fields
`define ITLI_STAT_CI_LO 0
`define ITLI_STAT_IND_BIT 8
`define ITLI_STAT_ALLOW_BIT 9
`define ITLI_STAT_BUSY_BIT 10

// ============================================================
// Frame layout
`define ITLI_TEN_LAST 8'h13
`define ITLI_TEN_D1 8'h08
`define ITLI_TEN_MAINT 8'h09
`define ITLI_TEN_B2_FIRST 8'h0A
`define ITLI_TEN_D2 8'h12
`define ITLI_TEN_AUX 8'h13
`define ITLI_FOUR_LAST 8'hFF
`define ITLI_FOUR_CH_BITS 8'h20
`define ITLI_FOUR_CI_FIRST 8'h1A
`define ITLI_FOUR_CI_LAST 8'h1F
`define ITLI_FOUR_CH2_BUSY 8'h5B

// ============================================================
// Controller slots
`define ITLI_CTRL_NUM 5
`define ITLI_CTRL_MGMT1 3'h3
`define ITLI_CTRL_MGMT2 3'h4
`define ITLI_CTRL_NONE 3'h7

`endif

// ### pkg/itli_pkg.sv
// Types shared by the line interface modules.
// Assumes itli_cfg.svh for the numeric constants.
package itli_pkg;

    // ============================================================
    // Modes and slot kinds
    typedef enum logic [1:0] {
        ITLI_MODE_OFF, ITLI_MODE_TEN, ITLI_MODE_FOUR
    } itli_mode_type;

    typedef enum logic [2:0] {
        ITLI_SLOT_NONE, ITLI_SLOT_B1, ITLI_SLOT_B2, ITLI_SLOT_D,
        ITLI_SLOT_MAINT, ITLI_SLOT_AUX
    } itli_slot_type;

    typedef struct packed {
        itli_slot_type kind;
        logic [2:0] bit_idx;
    } itli_slot_info_type;

endpackage

// ### pkg/itli_frame_if.sv
// Frame timing carried from the frame timer to the core.
// Assumes both ends run on clk_sys_in.
`timescale 1ns/1ps
interface itli_frame_if;
    import itli_pkg::*;
    itli_mode_type mode;
    logic bit_start;
    logic bit_sample;
    logic in_frame;
    logic data_clk;
    logic [7:0] bit_pos;

    modport timer(input mode, output bit_start, bit_sample, in_frame,
        data_clk, bit_pos);
    modport core(output mode, input bit_start, bit_sample, in_frame,
        data_clk, bit_pos);
endinterface

// ### verilog/itli_frame_timer.sv
// Frame timer: finds line clock edges and frame sync, counts bits.
// Assumes line clock and sync are synchronous to clk_sys_in.
`timescale 1ns/1ps
`include "itli_cfg.svh"
module itli_frame_timer
    import itli_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Line side
    input wire logic line_bit_clock_in,
    input wire logic frame_sync_in,
    // Timing to core
    itli_frame_if.timer fr
);
    logic lclk_prev_reg;
    logic armed_reg;
    logic phase_reg;
    logic in_frame_reg;
    logic [7:0] pos_reg;
    logic start_reg;
    logic sample_reg;
    logic dclk_reg;
    logic rise;
    logic fall;
    logic four;
    logic last;
    logic start_cond;
    logic sample_cond;

    // ============================================================
    // Edge detection
    assign rise = line_bit_clock_in && !lclk_prev_reg;
    assign fall = !line_bit_clock_in && lclk_prev_reg;
    assign four = (fr.mode == ITLI_MODE_FOUR);
    assign last = four ? (pos_reg == `ITLI_FOUR_LAST)
                       : (pos_reg == `ITLI_TEN_LAST);
    assign start_cond = !frame_sync_in && (armed_reg ||
        (in_frame_reg && !last && !(four && phase_reg)));
    assign sample_cond = in_frame_reg &&
        (four ? (rise && !frame_sync_in && phase_reg) : fall);

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            lclk_prev_reg <= 1'b0;
        end else begin
            lclk_prev_reg <= line_bit_clock_in;
        end
    end

    // ============================================================
    // Bit counter
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || fr.mode == ITLI_MODE_OFF) begin
            armed_reg <= 1'b0;
            in_frame_reg <= 1'b0;
            pos_reg <= 8'h00;
            phase_reg <= 1'b0;
        end else if (rise) begin
            if (frame_sync_in) begin
                armed_reg <= 1'b1;
                in_frame_reg <= 1'b0;
            end else if (armed_reg) begin
                armed_reg <= 1'b0;
                in_frame_reg <= 1'b1;
                pos_reg <= 8'h00;
                phase_reg <= 1'b1;
            end else if (in_frame_reg && four && phase_reg) begin
                phase_reg <= 1'b0;
            end else if (in_frame_reg) begin
                if (last) begin
                    in_frame_reg <= 1'b0;
                end else begin
                    pos_reg <= pos_reg + 8'h01;
                end
                phase_reg <= 1'b1;
            end
        end
    end

    // ============================================================
    // Pulses and data clock
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            start_reg <= 1'b0;
            sample_reg <= 1'b0;
        end else begin
            start_reg <= rise && start_cond && fr.mode != ITLI_MODE_OFF;
            sample_reg <= sample_cond;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in || !four) begin
            dclk_reg <= 1'b0;
        end else if (rise) begin
            dclk_reg <= start_cond;
        end
    end

    assign fr.bit_start = start_reg;
    assign fr.bit_sample = sample_reg;
    assign fr.in_frame = in_frame_reg;
    assign fr.bit_pos = pos_reg;
    assign fr.data_clk = dclk_reg;
endmodule

// ### verilog/itli_line_if.sv
// Time-division line interface core: channel routing, bit masking,
// bearer strobes, D-channel access and, in ITLI_MODE_FOUR only, line activation by forcing the line low.
// Assumes a line transceiver that supplies line clock and frame sync.
`timescale 1ns/1ps
`include "itli_cfg.svh"
module itli_line_if
    import itli_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wr_data_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rd_data_out,
    // Line pins
    input wire logic line_bit_clock_in,
    input wire logic frame_sync_in,
    input wire logic line_rx_data_in,
    output logic line_tx_data_out,
    output logic line_tx_data_oe_n_out,
    output logic dchan_request_out,
    input wire logic dchan_grant_in,
    output logic bearer_strobe_one_out,
    output logic bearer_strobe_two_out,
    output logic bus_data_clock_out,
    // Controller side
    output logic [4:0] ctrl_tx_req_out,
    input wire logic [4:0] ctrl_tx_bit_in,
    output logic [4:0] ctrl_rx_valid_out,
    output logic ctrl_rx_bit_out,
    input wire logic dchan_pending_in,
    output logic dchan_abort_out,
    output logic ind_irq_out
);
    itli_frame_if fr();

    logic [15:0] mode_reg;
    logic [15:0] mask_reg;
    logic irq_en_reg;
    logic ind_valid_reg;
    logic [5:0] ci_shift_reg;
    logic [5:0] ci_last_reg;
    logic busy_reg;
    logic d_allow_reg;
    logic pin_data_reg;
    logic pin_oe_n_reg;
    logic strobe1_reg;
    logic strobe2_reg;
    logic rx_bit_reg;
    logic [4:0] rx_valid_reg;
    logic abort_reg;
    logic [31:0] rd_data_reg;

    itli_mode_type cur_mode;
    itli_slot_info_type slot;
    logic [2:0] ctrl;
    logic ctrl_ok;
    logic b_en;
    logic rx_on;
    logic tx_on;
    logic tx_bit;
    logic four;
    logic force_low;
    logic term_ext;
    logic ind_set;
    logic [5:0] ci_next;
    logic busy_sample;
    logic collision;

    // ============================================================
    // Slot decode
    function automatic itli_slot_info_type slot_of(
        input itli_mode_type m, input logic [7:0] p);
        itli_slot_info_type s;
        s.kind = ITLI_SLOT_NONE;
        s.bit_idx = p[2:0];
        if (m == ITLI_MODE_TEN) begin
            if (p < `ITLI_TEN_D1) begin
                s.kind = ITLI_SLOT_B1;
            end else if (p == `ITLI_TEN_D1 || p == `ITLI_TEN_D2) begin
                s.kind = ITLI_SLOT_D;
            end else if (p == `ITLI_TEN_MAINT) begin
                s.kind = ITLI_SLOT_MAINT;
            end else if (p < `ITLI_TEN_D2) begin
                s.kind = ITLI_SLOT_B2;
                s.bit_idx = 3'(p - `ITLI_TEN_B2_FIRST);
            end else if (p == `ITLI_TEN_AUX) begin
                s.kind = ITLI_SLOT_AUX;
            end
        end else if (m == ITLI_MODE_FOUR && p < `ITLI_FOUR_CH_BITS) begin
            unique case (p[4:3])
                2'h0: s.kind = ITLI_SLOT_B1;
                2'h1: s.kind = ITLI_SLOT_B2;
                2'h2: s.kind = ITLI_SLOT_MAINT;
                2'h3: begin
                    if (p < `ITLI_FOUR_CI_FIRST) begin
                        s.kind = ITLI_SLOT_D;
                    end else begin
                        s.kind = ITLI_SLOT_AUX;
                    end
                end
            endcase
        end
        return s;
    endfunction

    function automatic logic [2:0] route_of(input logic [1:0] r);
        return (r == 2'h0) ? `ITLI_CTRL_NONE : {1'b0, r - 2'h1};
    endfunction

    // ============================================================
    // Mode and routing
    always_comb begin
        unique case (mode_reg[`ITLI_MODE_LO +: 2])
            `ITLI_MODE_TEN_CODE: cur_mode = ITLI_MODE_TEN;
            `ITLI_MODE_FOUR_CODE: cur_mode = ITLI_MODE_FOUR;
            default: cur_mode = ITLI_MODE_OFF;
        endcase
    end

    assign fr.mode = cur_mode;
    assign four = (cur_mode == ITLI_MODE_FOUR);
    assign force_low = four && mode_reg[`ITLI_FORCE_LOW_BIT];
    assign term_ext = four && mode_reg[`ITLI_SYNC_TERM_BIT];
    assign slot = slot_of(cur_mode, fr.bit_pos);

    always_comb begin
        unique case (slot.kind)
            ITLI_SLOT_B1: ctrl = route_of(mode_reg[`ITLI_B1_ROUTE_LO +: 2]);
            ITLI_SLOT_B2: ctrl = route_of(mode_reg[`ITLI_B2_ROUTE_LO +: 2]);
            ITLI_SLOT_D: ctrl = route_of(mode_reg[`ITLI_D_ROUTE_LO +: 2]);
            ITLI_SLOT_MAINT: ctrl = `ITLI_CTRL_MGMT1;
            ITLI_SLOT_AUX: ctrl = `ITLI_CTRL_MGMT2;
            default: ctrl = `ITLI_CTRL_NONE;
        endcase
    end

    assign ctrl_ok = (ctrl != `ITLI_CTRL_NONE);

    always_comb begin
        unique case (slot.kind)
            ITLI_SLOT_B1: b_en = mask_reg[{1'b0, slot.bit_idx}];
            ITLI_SLOT_B2: b_en = mask_reg[{1'b1, slot.bit_idx}];
            default: b_en = 1'b1;
        endcase
    end

    assign rx_on = fr.in_frame && ctrl_ok && b_en;
    assign tx_on = rx_on && !force_low &&
        (slot.kind != ITLI_SLOT_D || d_allow_reg);
    assign tx_bit = ctrl_ok ? ctrl_tx_bit_in[ctrl] : 1'b1;
    assign ctrl_tx_req_out = (fr.bit_start && tx_on) ? (5'h01 << ctrl)
                                                     : 5'h00;

    // ============================================================
    // Transmit pin
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            pin_data_reg <= 1'b1;
            pin_oe_n_reg <= 1'b1;
        end else if (force_low) begin
            pin_data_reg <= 1'b0;
            pin_oe_n_reg <= 1'b0;
        end else if (!fr.in_frame) begin
            pin_data_reg <= 1'b1;
            pin_oe_n_reg <= 1'b1;
        end else if (fr.bit_start) begin
            if (four) begin
                pin_data_reg <= 1'b0;
                pin_oe_n_reg <= !(tx_on && !tx_bit);
            end else begin
                pin_data_reg <= tx_bit;
                pin_oe_n_reg <= !tx_on;
            end
        end
    end

    assign line_tx_data_out = pin_data_reg;
    assign line_tx_data_oe_n_out = pin_oe_n_reg;

    // ============================================================
    // Bearer strobes
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || !fr.in_frame) begin
            strobe1_reg <= 1'b0;
            strobe2_reg <= 1'b0;
        end else if (fr.bit_start) begin
            strobe1_reg <= (slot.kind == ITLI_SLOT_B1) && b_en;
            strobe2_reg <= (slot.kind == ITLI_SLOT_B2) && b_en;
        end
    end

    assign bearer_strobe_one_out = strobe1_reg;
    assign bearer_strobe_two_out = strobe2_reg;
    assign bus_data_clock_out = fr.data_clk;

    // ============================================================
    // Receive path
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            rx_bit_reg <= 1'b0;
            rx_valid_reg <= 5'h00;
        end else if (fr.bit_sample && rx_on) begin
            rx_bit_reg <= line_rx_data_in;
            rx_valid_reg <= 5'h01 << ctrl;
        end else begin
            rx_valid_reg <= 5'h00;
        end
    end

    assign ctrl_rx_bit_out = rx_bit_reg;
    assign ctrl_rx_valid_out = rx_valid_reg;

    // ============================================================
    // Command/indication capture
    assign ci_next = {ci_shift_reg[4:0], line_rx_data_in};
    assign ind_set = four && fr.bit_sample &&
        fr.bit_pos == `ITLI_FOUR_CI_LAST && ci_next != ci_last_reg;
    assign busy_sample = four && fr.bit_sample &&
        fr.bit_pos == `ITLI_FOUR_CH2_BUSY;

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            ci_shift_reg <= 6'h00;
            ci_last_reg <= 6'h00;
        end else if (four && fr.bit_sample &&
                     slot.kind == ITLI_SLOT_AUX) begin
            ci_shift_reg <= ci_next;
            if (ind_set) begin
                ci_last_reg <= ci_next;
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            busy_reg <= 1'b0;
        end else if (busy_sample) begin
            busy_reg <= line_rx_data_in;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            ind_valid_reg <= 1'b0;
        end else if (ind_set) begin
            ind_valid_reg <= 1'b1;
        end else if (reg_wr_in && reg_addr_in == `ITLI_OFS_STATUS &&
                     reg_wr_data_in[`ITLI_STAT_IND_BIT]) begin
            ind_valid_reg <= 1'b0;
        end
    end

    assign ind_irq_out = ind_valid_reg && irq_en_reg;

    // ============================================================
    // D-channel access
    assign collision = dchan_pending_in && d_allow_reg && (
        (fr.bit_start && fr.in_frame && slot.kind == ITLI_SLOT_D &&
         !dchan_grant_in) ||
        (term_ext && busy_sample && line_rx_data_in));

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            d_allow_reg <= 1'b0;
        end else if (frame_sync_in) begin
            d_allow_reg <= dchan_grant_in &&
                !(term_ext && busy_reg);
        end else if (collision) begin
            d_allow_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            abort_reg <= 1'b0;
        end else begin
            abort_reg <= collision;
        end
    end

    assign dchan_abort_out = abort_reg;
    assign dchan_request_out = (cur_mode == ITLI_MODE_TEN) &&
        dchan_pending_in;

    // ============================================================
    // Register port
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            mode_reg <= `ITLI_MODE_RST;
            mask_reg <= `ITLI_MASK_RST;
            irq_en_reg <= 1'b0;
        end else if (reg_wr_in) begin
            unique case (reg_addr_in)
                `ITLI_OFS_MODE: mode_reg <= reg_wr_data_in[15:0];
                `ITLI_OFS_MASK: mask_reg <= reg_wr_data_in[15:0];
                `ITLI_OFS_IRQ_EN: irq_en_reg <= reg_wr_data_in[0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in || !reg_rd_in) begin
            rd_data_reg <= 32'h0000_0000;
        end else begin
            unique case (reg_addr_in)
                `ITLI_OFS_MODE: rd_data_reg <= {16'h0000, mode_reg};
                `ITLI_OFS_MASK: rd_data_reg <= {16'h0000, mask_reg};
                `ITLI_OFS_STATUS: rd_data_reg <= {21'h0, busy_reg,
                    d_allow_reg, ind_valid_reg, 2'h0, ci_last_reg};
                `ITLI_OFS_IRQ_EN: rd_data_reg <= {31'h0, irq_en_reg};
                default: rd_data_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign reg_rd_data_out = rd_data_reg;

    // ============================================================
    // Frame timer
    itli_frame_timer u_timer (
        .clk_sys_in(clk_sys_in),
        .reset_in(reset_in),
        .line_bit_clock_in(line_bit_clock_in),
        .frame_sync_in(frame_sync_in),
        .fr(fr.timer)
    );
endmodule

// ### verification/itli_line_if_asserts.sv
// Checker on the ports of the line interface top module.
// Assumes one clock, synchronous active-high reset.
`timescale 1ns/1ps
module itli_line_if_asserts (
    // Clock and register port
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wr_data_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rd_data_out,
    // Line and controller side
    input wire logic line_tx_data_out,
    input wire logic line_tx_data_oe_n_out,
    input wire logic dchan_request_out,
    input wire logic dchan_pending_in,
    input wire logic bearer_strobe_one_out,
    input wire logic bearer_strobe_two_out,
    input wire logic bus_data_clock_out,
    input wire logic [4:0] ctrl_tx_req_out,
    input wire logic [4:0] ctrl_rx_valid_out,
    input wire logic dchan_abort_out,
    input wire logic ind_irq_out
);
    // ============================================================
    // Shadow of mode and interrupt enable
    logic [1:0] mode_q;
    logic force_q;
    logic irq_en_q;
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            mode_q <= 2'h0;
            force_q <= 1'b0;
        end else if (reg_wr_in && reg_addr_in == 8'h00) begin
            mode_q <= reg_wr_data_in[1:0];
            force_q <= reg_wr_data_in[15];
        end
    end
    always_ff @(posedge clk_sys_in) begin
        if (reset_in)
            irq_en_q <= 1'b0;
        else if (reg_wr_in && reg_addr_in == 8'h0C)
            irq_en_q <= reg_wr_data_in[0];
    end
    // ============================================================
    // Properties
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    sequence s_four2;
        (mode_q == 2'h2) [*2];
    endsequence
    sequence s_force2;
        (force_q && mode_q == 2'h2) [*2];
    endsequence
    property p_req;
        dchan_request_out == (dchan_pending_in && mode_q == 2'h1);
    endproperty
    a_req: assert property (p_req) else $error("request wrong");
    property p_strobe;
        !(bearer_strobe_one_out && bearer_strobe_two_out);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobes");
    property p_dclk;
        bus_data_clock_out |-> $past(mode_q) == 2'h2;
    endproperty
    a_dclk: assert property (p_dclk) else $error("data clock");
    property p_force;
        s_force2 |-> !line_tx_data_out && !line_tx_data_oe_n_out;
    endproperty
    a_force: assert property (p_force) else $error("force");
    property p_drain;
        s_four2 ##0 !line_tx_data_oe_n_out |-> !line_tx_data_out;
    endproperty
    a_drain: assert property (p_drain) else $error("drain");
    property p_rst;
        disable iff (1'b0) reset_in |=> line_tx_data_out &&
            line_tx_data_oe_n_out && !bus_data_clock_out;
    endproperty
    a_rst: assert property (p_rst) else $error("reset pins");
    property p_rd0;
        !reg_rd_in |=> reg_rd_data_out == 32'h0;
    endproperty
    a_rd0: assert property (p_rd0) else $error("read data");
    property p_rx_off;
        (mode_q == 2'h0) [*2] |-> ctrl_rx_valid_out == 5'h0;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx off");
    property p_hot;
        $onehot0(ctrl_tx_req_out) && $onehot0(ctrl_rx_valid_out);
    endproperty
    a_hot: assert property (p_hot) else $error("routing");
    property p_abort;
        dchan_abort_out |=> !dchan_abort_out;
    endproperty
    a_abort: assert property (p_abort) else $error("abort");
    property p_irq;
        ind_irq_out |-> irq_en_q;
    endproperty
    a_irq: assert property (p_irq) else $error("irq mask");
endmodule
bind itli_line_if itli_line_if_asserts u_chk (.*);

// ### verification/itli_xcvr_model.sv
// Line transceiver model: line clock, frame sync, rx data, grant.
// Assumes eight system clocks per line clock period.
`timescale 1ns/1ps
module itli_xcvr_model (
    // Bench control
    input wire logic clk_sys_in,
    input wire logic run_in,
    input wire logic four_in,
    input wire logic grant_in,
    input wire logic [31:0] rx_pat_in,
    // Line pins
    output logic line_bit_clock_out,
    output logic frame_sync_out,
    output logic line_rx_data_out,
    output logic dchan_grant_out
);
    // ============================================================
    // Line clock and frame counter
    logic [2:0] ph_reg = 3'h0;
    logic [9:0] per_reg = 10'h0;
    logic [9:0] last;
    logic pat_bit;
    assign last = four_in ? 10'h207 : 10'h017;
    always @(posedge clk_sys_in) begin
        if (run_in) begin
            ph_reg <= ph_reg + 3'h1;
            if (ph_reg == 3'h3)
                per_reg <= (per_reg == last) ? 10'h0 : per_reg + 10'h1;
        end
    end
    assign line_bit_clock_out = run_in & ph_reg[2];
    assign frame_sync_out = (per_reg == last);
    // Pull-up level outside the covered bits
    assign pat_bit = four_in ? (per_reg < 10'h40 && rx_pat_in[per_reg[5:1]])
        : (per_reg > 10'h13 || rx_pat_in[per_reg[4:0]]);
    assign line_rx_data_out = !run_in || (four_in && per_reg > 10'h3F)
        || pat_bit;
    assign dchan_grant_out = grant_in;
endmodule

// ### verification/test_itli_line_if.sv
// Self-checking bench for the line interface core.
// Assumes the transceiver model and the bound checker.
`timescale 1ns/1ps
module test_itli_line_if;
    logic clk_sys_in;
    logic reset_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [31:0] reg_wr_data_in = 32'h0;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [31:0] reg_rd_data_out, v;
    logic line_bit_clock_in, frame_sync_in, line_rx_data_in, grant;
    logic line_tx_data_out, line_tx_data_oe_n_out, dchan_request_out;
    logic bearer_strobe_one_out, bearer_strobe_two_out, bus_data_clock_out;
    logic [4:0] ctrl_tx_req_out, ctrl_rx_valid_out;
    logic [4:0] ctrl_tx_bit_in = 5'h15;
    logic ctrl_rx_bit_out, dchan_abort_out, ind_irq_out;
    logic dchan_pending_in = 1'b0;
    logic dchan_grant_in = 1'b1;
    logic run = 1'b1;
    logic four = 1'b0;
    logic [31:0] pat = 32'h1;
    logic s1_q, s2_q, dc_q;
    logic [7:0] got0;
    int bad_count = 0;
    int num_checks = 0;
    int n_rx[5], n_req[5], n_s1, n_s2, n_dc, n_ab;
    // ============================================================
    // Design, partner and monitor
    itli_line_if dut_u (.*);
    itli_xcvr_model xcvr_u (.clk_sys_in(clk_sys_in), .run_in(run),
        .four_in(four), .grant_in(dchan_grant_in), .rx_pat_in(pat),
        .line_bit_clock_out(line_bit_clock_in),
        .frame_sync_out(frame_sync_in), .line_rx_data_out(line_rx_data_in),
        .dchan_grant_out(grant));
    initial begin
        clk_sys_in = 1'b0;
        forever #50 clk_sys_in = ~clk_sys_in;
    end
    always @(posedge clk_sys_in) begin
        for (int i = 0; i < 5; i++) begin
            n_rx[i] += ctrl_rx_valid_out[i];
            n_req[i] += ctrl_tx_req_out[i];
        end
        if (ctrl_rx_valid_out[0] === 1'b1)
            got0 = {got0[6:0], ctrl_rx_bit_out};
        n_s1 += bearer_strobe_one_out & ~s1_q;
        n_s2 += bearer_strobe_two_out & ~s2_q;
        n_dc += bus_data_clock_out & ~dc_q;
        n_ab += dchan_abort_out;
        s1_q = bearer_strobe_one_out;
        s2_q = bearer_strobe_two_out;
        dc_q = bus_data_clock_out;
    end
    // ============================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wr_data_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1 d = reg_rd_data_out;
    endtask
    task automatic frames(input int n);
        repeat (n) @(posedge frame_sync_in);
    endtask
    task automatic window();
        @(posedge frame_sync_in);
        n_rx = '{default: 0};
        n_req = '{default: 0};
        n_s1 = 0;
        n_s2 = 0;
        n_dc = 0;
        @(posedge frame_sync_in);
    endtask
    // ============================================================
    // Scenarios
    task automatic t_regs();
        rd(8'h00, v);
        chk(v, 32'h0);
        rd(8'h04, v);
        chk(v, 32'hFFFF);
        wr(8'h00, 32'h8000);
        rd(8'h00, v);
        chk(v, 32'h8000);
        rd(8'h10, v);
        chk({v[30:0], line_tx_data_oe_n_out}, 32'h1);
    endtask
    task automatic t_ten();
        wr(8'h04, 32'h5);
        wr(8'h00, 32'h361);
        frames(1);
        window();
        chk({n_rx[0][15:0], n_rx[2][15:0]}, 32'h2_0000);
        chk(n_rx[1], 32'h2);
        chk(n_rx[3] + n_rx[4], 32'h2);
        chk(n_req[0] + n_req[2], 32'h2);
        chk({n_s1[15:0], n_s2[15:0]}, 32'h2_0000);
        chk(got0[1:0], 32'h2);
    endtask
    task automatic t_dchan();
        dchan_pending_in <= 1'b1;
        dchan_grant_in <= 1'b0;
        frames(2);
        rd(8'h08, v);
        chk({dchan_request_out, v[9]}, 32'h2);
        dchan_grant_in <= 1'b1;
        frames(1);
        rd(8'h08, v);
        chk(v[9], 32'h1);
        @(negedge frame_sync_in);
        n_ab = 0;
        dchan_grant_in <= 1'b0;
        frames(1);
        chk(n_ab, 32'h1);
        dchan_grant_in <= 1'b1;
    endtask
    task automatic t_four();
        pat <= 32'hFC00_0000;
        four <= 1'b1;
        wr(8'h0C, 32'h1);
        wr(8'h00, 32'h2);
        frames(1);
        window();
        chk(n_dc, 32'h100);
        chk({n_rx[3][15:0], n_rx[4][15:0]}, 32'h8_0006);
        rd(8'h08, v);
        chk({ind_irq_out, v[10:0]}, 32'hF3F);
        wr(8'h08, 32'h100);
        frames(1);
        chk(ind_irq_out, 32'h0);
        wr(8'h00, 32'h4002);
        frames(2);
        rd(8'h08, v);
        chk(v[9], 32'h0);
        wr(8'h00, 32'h2);
        dchan_grant_in <= 1'b0;
        frames(2);
        rd(8'h08, v);
        chk(v[9], 32'h0);
        wr(8'h00, 32'h8002);
        run <= 1'b0;
        repeat (20) @(posedge clk_sys_in);
        chk({line_tx_data_out, line_tx_data_oe_n_out}, 32'h0);
        run <= 1'b1;
        wr(8'h00, 32'h2);
        frames(1);
        chk(line_tx_data_oe_n_out, 32'h1);
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        t_regs();
        t_ten();
        t_dchan();
        t_four();
        conclude();
    end
    initial begin
        #9000000;
        bad_count++;
        conclude();
    end
endmodule
